// >>> sac_adc_ctrl.sv
// Behaviour
// - Input at or above high reference gives all ones, at or below zero.
// - Ten-bit result spans both registers; eight-bit rounds into low only.
// - Completion moves result, sets flag, interrupts if enabled then.
// - Clock source: async if enabled, else bus or alternate by select.
// - Async clock runs only while converting with it; rate by low power.
// - Selected source is divided by 1, 2, 4 or 8 by the field.
// - Only the channel in the status register is converted.
// - Each conversion uses ten or eight bits per the mode field.
// - Status write with channel not all ones starts a conversion.
// - Software status writes start conversions; continuous repeats until abort.
// - Continuous mode restarts after every transfer until aborted.
// - Split ten-bit read blocks transfer, drops result, restarts.
// - Status write, config write, reset or stop without async abort.
// - Abort keeps last result; reset restores reset values.
// - Reset, or abort without a new start, drops to idle with clocks disabled at once.
// - Eight-bit short sample: 18 clocks first, 16 subsequent.
// - Eight-bit long sample: 38 clocks first, 36 subsequent.
// - Ten-bit short sample: 21 clocks first, 19 subsequent.
// - Ten-bit long sample: 41 clocks first, 39 subsequent.
// - Flag sets after every good conversion whatever interrupt enable.
// - No hardware trigger exists; only software and continuous starts.
// - Alternate clock source is four times the bus clock; here it ticks once per bus clock, like the bus source.
// - Results right justified, unused upper bits read zero.
`timescale 1ns/1ps
module sac_adc_ctrl (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // Register port
  input  wire logic [sac_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [sac_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [sac_pkg::DATA_W-1:0]  regRdata,
  // Power mode
  input  wire logic                        stopMode,
  // Analog side
  output logic      [4:0]                  muxChannel,
  output logic                             sampleHold,
  output logic      [sac_pkg::RES_W-1:0]   dacCode,
  input  wire logic                        compHigh,
  // Status
  output logic                             asyncClockRun,
  output logic                             convBusy,
  output logic                             irqReq
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sac_state_e state_reg;
  sac_state_e state_next;
  logic       ienBit_reg;
  logic       contEn_reg;
  logic [4:0] chSel_reg;
  logic       cfgLowPwr_reg;
  logic [1:0] cfgDiv_reg;
  logic       cfgLongSmp_reg;
  logic [1:0] cfgMode_reg;
  logic       cfgIclk_reg;
  logic       cfgAclk_reg;
  logic [1:0] resHigh_reg;
  logic [7:0] resLow_reg;
  logic       flag_reg;
  logic       highRead_reg;
  logic [5:0] remain_reg;
  logic [5:0] total_reg;
  logic [9:0] warmCnt_reg;
  logic [7:0] oscCnt_reg;
  logic [5:0] adckSeen_reg;
  logic       stsWr;
  logic       cfgWr;
  logic       resHRd;
  logic       resLRd;
  logic       tenBit;
  logic       startReq;
  logic       abortEv;
  logic       blocked;
  logic       xferOk;
  logic       loadConv;
  logic       fromXfer;
  logic       convDone;
  logic       sarStep;
  logic       oscTick;
  logic       srcTick;
  logic       adckTick;
  logic [5:0] baseLen;
  logic [10:0] roundSum;
  logic [7:0] round8;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign stsWr    = regWr && regAddr == STS_OFF;
  assign cfgWr    = regWr && regAddr == CFG_OFF;
  assign resHRd   = regRd && regAddr == RESH_OFF;
  assign resLRd   = regRd && regAddr == RESL_OFF;
  assign tenBit   = cfgMode_reg == MODE_10;
  assign startReq = stsWr && regWdata[4:0] != CH_OFF;
  // Only software writes start work; there is no trigger input
  assign abortEv  = stsWr || cfgWr ||
                    (stopMode && !cfgAclk_reg && state_reg != ST_IDLE);

  // Status and control fields; a write also aborts and may restart
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ienBit_reg <= STS_RST[STS_IEN_BIT];
      contEn_reg <= STS_RST[STS_CONT_BIT];
      chSel_reg  <= STS_RST[4:0];
    end else if (stsWr) begin
      ienBit_reg <= regWdata[STS_IEN_BIT];
      contEn_reg <= regWdata[STS_CONT_BIT];
      chSel_reg  <= regWdata[4:0];
    end
  end

  // Clock, sample length and mode configuration fields
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfgLowPwr_reg  <= CFG_RST[CFG_LP_BIT];
      cfgDiv_reg     <= CFG_RST[CFG_DIV_LSB +: 2];
      cfgLongSmp_reg <= CFG_RST[CFG_LSMP_BIT];
      cfgMode_reg    <= CFG_RST[CFG_MODE_LSB +: 2];
      cfgIclk_reg    <= CFG_RST[CFG_ICLK_BIT];
      cfgAclk_reg    <= CFG_RST[CFG_ACLK_BIT];
    end else if (cfgWr) begin
      cfgLowPwr_reg  <= regWdata[CFG_LP_BIT];
      cfgDiv_reg     <= regWdata[CFG_DIV_LSB +: 2];
      cfgLongSmp_reg <= regWdata[CFG_LSMP_BIT];
      cfgMode_reg    <= regWdata[CFG_MODE_LSB +: 2];
      cfgIclk_reg    <= regWdata[CFG_ICLK_BIT];
      cfgAclk_reg    <= regWdata[CFG_ACLK_BIT];
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        STS_OFF:  regRdata <= {flag_reg, ienBit_reg, contEn_reg, chSel_reg};
        RESH_OFF: regRdata <= {6'h00, resHigh_reg};
        RESL_OFF: regRdata <= resLow_reg;
        CFG_OFF:  regRdata <= {cfgLowPwr_reg, cfgDiv_reg, cfgLongSmp_reg,
                               cfgMode_reg, cfgIclk_reg, cfgAclk_reg};
        default:  regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Converter clock source
  // ----------------------------------------------------------------
  // Internal oscillator modelled as a tick every 64 or 128 bus clocks
  always_ff @(posedge sys_clk) begin
    if (!resetn || !asyncClockRun) begin
      oscCnt_reg <= 8'h00;
    end else if (oscCnt_reg == 8'h00) begin
      oscCnt_reg <= cfgLowPwr_reg ? 8'(ASYNC_SLOW_CYC - 1)
                                  : 8'(ASYNC_FAST_CYC - 1);
    end else begin
      oscCnt_reg <= oscCnt_reg - 8'h01;
    end
  end
  assign oscTick = asyncClockRun && oscCnt_reg == 8'h00;

  // Bus and alternate sources both tick every cycle here: the fourfold
  // alternate clock cannot be faster than the one clock this block has
  assign srcTick = cfgAclk_reg ? oscTick
                 : (cfgIclk_reg ? 1'b1 : 1'b1);

  sac_clk_div u_div (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .run      (state_reg == ST_CONV),
    .srcTick  (srcTick),
    .divSel   (cfgDiv_reg),
    .adckTick (adckTick)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  assign blocked  = tenBit && highRead_reg;
  assign xferOk   = state_reg == ST_XFER && !blocked && !abortEv;
  assign convDone = state_reg == ST_CONV && adckTick &&
                    remain_reg == 6'h01;
  assign sarStep  = state_reg == ST_CONV && adckTick &&
                    remain_reg <= SAR_STEPS;
  assign fromXfer = state_reg == ST_XFER && !blocked && !abortEv;
  assign loadConv = state_next == ST_CONV &&
                    (state_reg != ST_CONV || abortEv);

  // Next state; an abort wins over everything and drops to idle unless a status write starts anew
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_WARM: if (warmCnt_reg == 10'h000) begin
        state_next = ST_CONV;
      end
      ST_CONV: if (convDone) begin
        state_next = ST_XFER;
      end
      ST_XFER: if (blocked || contEn_reg) begin
        state_next = ST_CONV;
      end else begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (abortEv) begin
      if (startReq && cfgAclk_reg && !asyncClockRun) begin
        state_next = ST_WARM;
      end else if (startReq) begin
        state_next = ST_CONV;
      end else begin
        state_next = ST_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Oscillator start-up allowance before the first async conversion
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      warmCnt_reg <= 10'h000;
    end else if (state_next == ST_WARM && state_reg != ST_WARM) begin
      warmCnt_reg <= 10'(ASYNC_START_CYC - 1);
    end else if (warmCnt_reg != 10'h000) begin
      warmCnt_reg <= warmCnt_reg - 10'h001;
    end
  end

  // Length in converter clocks; a first conversion takes two more
  always_comb begin
    case ({tenBit, cfgLongSmp_reg})
      2'b00:   baseLen = CONVERTER_CLOCK_8S;
      2'b01:   baseLen = CONVERTER_CLOCK_8L;
      2'b10:   baseLen = CONVERTER_CLOCK_10S;
      2'b11:   baseLen = CONVERTER_CLOCK_10L;
      default: baseLen = CONVERTER_CLOCK_8S;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      remain_reg <= 6'h00;
      total_reg  <= 6'h00;
    end else if (loadConv) begin
      remain_reg <= fromXfer ? baseLen : baseLen + FIRST_EXTRA;
      total_reg  <= fromXfer ? baseLen : baseLen + FIRST_EXTRA;
    end else if (state_reg == ST_CONV && adckTick) begin
      remain_reg <= remain_reg - 6'h01;
    end
  end

  // Channel is latched at start so it cannot move mid-conversion
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      muxChannel    <= STS_RST[4:0];
      sampleHold    <= 1'b0;
      asyncClockRun <= 1'b0;
      convBusy      <= 1'b0;
    end else begin
      if (loadConv) begin
        muxChannel <= stsWr ? regWdata[4:0] : chSel_reg;
      end
      sampleHold    <= state_next == ST_CONV && !sarStep &&
                       (loadConv || remain_reg > SAR_STEPS);
      asyncClockRun <= cfgAclk_reg && state_next != ST_IDLE;
      convBusy      <= state_next != ST_IDLE;
    end
  end

  sac_sar_core u_sar (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .load      (loadConv),
    .step      (sarStep),
    .compHigh  (compHigh),
    .trialCode (dacCode)
  );

  // ----------------------------------------------------------------
  // Result transfer, flag and interrupt
  // ----------------------------------------------------------------
  // Round to nearest and saturate at all ones
  assign roundSum = {1'b0, dacCode} + 11'h002;
  assign round8   = roundSum[10] ? 8'hff : roundSum[9:2];

  // Results move only on a clean transfer; aborts leave them alone
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      resHigh_reg <= 2'h0;
      resLow_reg  <= 8'h00;
    end else if (xferOk) begin
      if (tenBit) begin
        resHigh_reg <= dacCode[9:8];
        resLow_reg  <= dacCode[7:0];
      end else begin
        resHigh_reg <= 2'h0;
        resLow_reg  <= round8;
      end
    end
  end

  // Split-read tracker: high read opens, low read closes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      highRead_reg <= 1'b0;
    end else if (resHRd && tenBit) begin
      highRead_reg <= 1'b1;
    end else if (resLRd) begin
      highRead_reg <= 1'b0;
    end
  end

  // Flag and interrupt: a transfer in the clearing cycle still sets
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
      irqReq   <= 1'b0;
    end else if (xferOk) begin
      flag_reg <= 1'b1;
      irqReq   <= ienBit_reg;
    end else if (stsWr || resLRd) begin
      flag_reg <= 1'b0;
      irqReq   <= 1'b0;
    end
  end

  // Helper for checks: converter clocks seen in the current run
  always_ff @(posedge sys_clk) begin
    if (!resetn || loadConv) begin
      adckSeen_reg <= 6'h00;
    end else if (state_reg == ST_CONV && adckTick) begin
      adckSeen_reg <= adckSeen_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence goodXfer;
    state_reg == ST_XFER && !blocked && !regWr && !resLRd;
  endsequence

  sequence blockedXfer;
    state_reg == ST_XFER && blocked && !regWr;
  endsequence

  chk_flag_sets : assert property (goodXfer |=> flag_reg)
    else $error("flag not set after transfer");
  chk_block_restart : assert property (
    blockedXfer |=> state_reg == ST_CONV && $stable(resLow_reg))
    else $error("blocked transfer did not restart");
  chk_irq_gated : assert property (
    goodXfer ##0 !ienBit_reg |=> !irqReq)
    else $error("interrupt raised while disabled");
  chk_cfg_abort : assert property (
    cfgWr |=> state_reg == ST_IDLE && !convBusy)
    else $error("config write did not abort");
  chk_abort_keeps : assert property (
    abortEv |=> $stable(resLow_reg) && $stable(resHigh_reg))
    else $error("abort altered result");
  chk_short_high : assert property (
    goodXfer ##0 !tenBit |=> resHigh_reg == 2'h0)
    else $error("eight-bit result leaked into high");
  chk_sw_start : assert property (
    startReq && !cfgAclk_reg |=> state_reg == ST_CONV ##1 convBusy)
    else $error("software write did not start");
  chk_cont_again : assert property (
    goodXfer ##0 contEn_reg |=> state_reg == ST_CONV)
    else $error("continuous mode did not restart");
  chk_async_gate : assert property (
    asyncClockRun |-> cfgAclk_reg && state_reg != ST_IDLE)
    else $error("async clock running while idle");
  chk_conv_length : assert property (
    state_reg == ST_CONV ##1 state_reg == ST_XFER |->
    adckSeen_reg == total_reg)
    else $error("conversion length wrong");

endmodule : sac_adc_ctrl

// >>> sac_clk_div.sv
`timescale 1ns/1ps
module sac_clk_div (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       run,
  input  wire logic       srcTick,
  input  wire logic [1:0] divSel,
  // Converter clock tick
  output logic            adckTick
);
  import sac_pkg::*;

  logic [2:0] divCnt_reg;
  logic [2:0] divLast;

  // Ratio 1, 2, 4 or 8 from the two-bit field
  assign divLast = 3'((4'h1 << divSel) - 4'h1);

  // Count source ticks; divider is held cleared whenever the state is not convert
  always_ff @(posedge sys_clk) begin
    if (!resetn || !run) begin
      divCnt_reg <= 3'h0;
      adckTick   <= 1'b0;
    end else begin
      adckTick <= 1'b0;
      if (srcTick) begin
        if (divCnt_reg == divLast) begin
          divCnt_reg <= 3'h0;
          adckTick   <= 1'b1;
        end else begin
          divCnt_reg <= divCnt_reg + 3'h1;
        end
      end
    end
  end

  sequence quietSeven;
    !adckTick [*7];
  endsequence

  chk_div_eight_gap : assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (adckTick && divSel == 2'b11 && run) |=> quietSeven)
    else $error("divide-by-8 tick came early");

endmodule : sac_clk_div

// >>> sac_mux_model.sv
`timescale 1ns/1ps
module sac_mux_model (
  // Clock
  input  wire logic       sys_clk,
  // Input level set by the bench
  input  wire logic [9:0] level,
  // Converter side
  input  wire logic [4:0] muxChannel,
  input  wire logic       sampleHold,
  input  wire logic [9:0] dacCode,
  output logic            compHigh
);
  // ----------------------------------------------------------------
  // Sample and hold
  // ----------------------------------------------------------------
  logic [9:0] heldLevel;

  // Each channel sees its own level, so a wrong channel shows up
  always_ff @(posedge sys_clk) begin
    if (sampleHold) begin
      heldLevel <= level ^ {muxChannel, 5'h00};
    end
  end

  // Ideal comparator, high at or above the trial code
  assign compHigh = (heldLevel >= dacCode);
endmodule : sac_mux_model

// >>> sac_pkg.sv
package sac_pkg;

  // ----------------------------------------------------------------
  // Bus and widths
  // ----------------------------------------------------------------
  localparam int        DATA_W  = 8;
  localparam int        ADDR_W  = 8;
  localparam int        RES_W   = 10;
  localparam int        BUS_MHZ = 125;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] STS_OFF  = 8'h00;
  localparam logic [7:0] RESH_OFF = 8'h01;
  localparam logic [7:0] RESL_OFF = 8'h02;
  localparam logic [7:0] CFG_OFF  = 8'h03;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         STS_FLAG_BIT = 7;
  localparam int         STS_IEN_BIT  = 6;
  localparam int         STS_CONT_BIT = 5;
  localparam int         CFG_LP_BIT   = 7;
  localparam int         CFG_DIV_LSB  = 5;
  localparam int         CFG_LSMP_BIT = 4;
  localparam int         CFG_MODE_LSB = 2;
  localparam int         CFG_ICLK_BIT = 1;
  localparam int         CFG_ACLK_BIT = 0;
  localparam logic [4:0] CH_OFF       = 5'h1f;
  localparam logic [7:0] STS_RST      = 8'h1f;
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [1:0] MODE_8       = 2'h0;
  localparam logic [1:0] MODE_10      = 2'h1;
  localparam logic [9:0] SAR_MSB      = 10'h200;

  // ----------------------------------------------------------------
  // Conversion lengths in converter clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] CONVERTER_CLOCK_8S     = 6'h10;
  localparam logic [5:0] CONVERTER_CLOCK_8L     = 6'h24;
  localparam logic [5:0] CONVERTER_CLOCK_10S    = 6'h13;
  localparam logic [5:0] CONVERTER_CLOCK_10L    = 6'h27;
  localparam logic [5:0] FIRST_EXTRA = 6'h02;
  localparam logic [5:0] SAR_STEPS   = 6'h0a;

  // ----------------------------------------------------------------
  // Timing of the internal asynchronous oscillator
  // ----------------------------------------------------------------
  localparam int ASYNC_START_NS = 5000;
  localparam int ASYNC_FAST_NS  = 512;
  localparam int ASYNC_SLOW_NS  = 1024;
  localparam int ASYNC_START_CYC = (ASYNC_START_NS * BUS_MHZ + 999) / 1000;
  localparam int ASYNC_FAST_CYC  = (ASYNC_FAST_NS * BUS_MHZ) / 1000;
  localparam int ASYNC_SLOW_CYC  = (ASYNC_SLOW_NS * BUS_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Controller states, Gray coded along idle-warm-convert-transfer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WARM = 2'b01,
    ST_CONV = 2'b11,
    ST_XFER = 2'b10
  } sac_state_e;

endpackage : sac_pkg

// >>> sac_sar_core.sv
`timescale 1ns/1ps
module sac_sar_core (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Sequencing
  input  wire logic       load,
  input  wire logic       step,
  input  wire logic       compHigh,
  // Trial code to the comparator, final after ten steps
  output logic [9:0]      trialCode
);
  import sac_pkg::*;

  logic [9:0] bitMask_reg;

  // One bit decided per step, MSB first; a stuck-high comparator
  // walks to all ones and a stuck-low one to zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      trialCode   <= 10'h000;
      bitMask_reg <= 10'h000;
    end else if (load) begin
      trialCode   <= SAR_MSB;
      bitMask_reg <= SAR_MSB;
    end else if (step && bitMask_reg != 10'h000) begin
      if (compHigh) begin
        trialCode <= trialCode | (bitMask_reg >> 1);
      end else begin
        trialCode <= (trialCode & ~bitMask_reg) | (bitMask_reg >> 1);
      end
      bitMask_reg <= bitMask_reg >> 1;
    end
  end

endmodule : sac_sar_core

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import sac_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk  = 1'b0;
  logic        resetn   = 1'b0;
  logic [7:0]  regAddr  = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic        stopMode = 1'b0;
  logic [9:0]  level    = 10'h000;
  logic [7:0]  regRdata;
  logic [4:0]  muxChannel;
  logic [9:0]  dacCode;
  logic        sampleHold, compHigh, asyncClockRun, convBusy, irqReq;
  logic        rdDly    = 1'b0;
  logic [7:0]  expQ[$];
  int          errors   = 0;
  int          nTests   = 0;

  always #4 sys_clk = ~sys_clk;

  sac_adc_ctrl sac_adc_ctrl_i (.sys_clk, .resetn, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .stopMode, .muxChannel, .sampleHold,
    .dacCode, .compHigh, .asyncClockRun, .convBusy, .irqReq);
  sac_mux_model sac_mux_model_i (.sys_clk, .level, .muxChannel,
    .sampleHold, .dacCode, .compHigh);

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                     input string what);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
               got, exp);
    end
  endtask : chk

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rdDly <= regRd;
    if (rdDly) begin
      chk({2'h0, regRdata}, {2'h0, expQ.pop_front()}, "read");
    end
  end

  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  // Counts busy cycles, bounded so a stuck machine cannot hang
  task automatic wait_done(output int n);
    n = 0;
    #1;
    while (convBusy === 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({9'h0, n < 4000}, 10'h001, "busy timeout");
    repeat (3) @(posedge sys_clk);
  endtask : wait_done

  task automatic convert(input logic [7:0] cfg, input logic [7:0] sts,
                         input logic [9:0] lvl);
    logic [9:0] code;
    logic [9:0] r8;
    logic [5:0] t;
    logic       ten;
    int         n;
    int         d;
    code = lvl ^ {sts[4:0], 5'h00};
    r8   = (code >= 10'h3fe) ? 10'h0ff : (code + 10'h002) >> 2;
    ten  = (cfg[3:2] == MODE_10);
    t    = ten ? (cfg[4] ? CONVERTER_CLOCK_10L : CONVERTER_CLOCK_10S)
               : (cfg[4] ? CONVERTER_CLOCK_8L : CONVERTER_CLOCK_8S);
    t    = t + FIRST_EXTRA;
    d    = 1 << cfg[6:5];
    level <= lvl;
    wr(CFG_OFF, cfg);
    wr(STS_OFF, sts);
    if (cfg[0]) begin
      repeat (4) @(posedge sys_clk);
      #1;
      chk({9'h0, asyncClockRun}, 10'h001, "async run");
    end
    wait_done(n);
    if (!cfg[0]) begin
      chk({9'h0, n >= t * d && n <= t * d + d + 3},
          10'h001, "time");
    end
    chk({9'h0, asyncClockRun}, 10'h000, "async off");
    chk({9'h0, irqReq}, {9'h0, sts[6]}, "irq");
    rd(STS_OFF, {1'b1, sts[6:0]});
    rd(RESH_OFF, ten ? {6'h00, code[9:8]} : 8'h00);
    rd(RESL_OFF, ten ? code[7:0] : r8[7:0]);
    rd(STS_OFF, {1'b0, sts[6:0]});
  endtask : convert

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // Longest path is well under this many cycles
  initial begin
    #(40000 * 8);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] cfg;
    logic [9:0] a;
    logic [9:0] b;
    int         n;
    void'($urandom(7));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(STS_OFF, STS_RST);
    rd(RESH_OFF, 8'h00);
    rd(RESL_OFF, 8'h00);
    rd(CFG_OFF, CFG_RST);
    rd(8'h07, 8'h00);
    $display("reset values done");
    // Every divider, sample length and mode; extremes on channel 0
    for (int i = 0; i < 16; i++) begin
      cfg = {1'b0, i[1:0], i[2], 1'b0, i[3], 1'($urandom), 1'b0};
      a = (i % 8 == 0) ? 10'h000 : (i % 8 == 1) ? 10'h3ff : 10'($urandom);
      convert(cfg, {1'b0, 1'($urandom), 1'b0,
                    (i % 8 < 2) ? 5'h00 : 5'($urandom % 31)}, a);
    end
    convert(8'h85, 8'h45, 10'($urandom));
    $display("sweep done");
    // Continuous run then abort by a write with the channel off
    a = 10'($urandom);
    level <= a;
    wr(CFG_OFF, 8'h04);
    wr(STS_OFF, 8'h23);
    repeat (60) @(posedge sys_clk);
    rd(STS_OFF, 8'ha3);
    rd(RESH_OFF, {6'h00, a[9:8] ^ 2'h0});
    rd(RESL_OFF, a[7:0] ^ 8'h60);
    repeat (30) @(posedge sys_clk);
    rd(STS_OFF, 8'ha3);
    level <= ~a;
    wr(STS_OFF, 8'h1f);
    #1;
    chk({9'h0, convBusy}, 10'h000, "abort");
    rd(RESL_OFF, a[7:0] ^ 8'h60);
    rd(STS_OFF, 8'h1f);
    $display("continuous done");
    // Half-read result blocks the next transfer
    a = 10'($urandom);
    b = ~a;
    convert(8'h04, 8'h02, a);
    rd(RESH_OFF, {6'h00, a[9:8]});
    level <= b;
    wr(STS_OFF, 8'h02);
    repeat (30) @(posedge sys_clk);
    #1;
    chk({9'h0, convBusy}, 10'h001, "restart");
    rd(STS_OFF, 8'h02);
    rd(RESL_OFF, a[7:0] ^ 8'h40);
    wait_done(n);
    rd(STS_OFF, 8'h82);
    rd(RESH_OFF, {6'h00, b[9:8]});
    rd(RESL_OFF, b[7:0] ^ 8'h40);
    $display("blocking done");
    // Stop entry and a config write both abort
    wr(STS_OFF, 8'h04);
    repeat (5) @(posedge sys_clk);
    stopMode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({9'h0, convBusy}, 10'h000, "stop abort");
    @(posedge sys_clk);
    stopMode <= 1'b0;
    wr(STS_OFF, 8'h04);
    repeat (5) @(posedge sys_clk);
    wr(CFG_OFF, 8'h04);
    #1;
    chk({9'h0, convBusy}, 10'h000, "cfg abort");
    rd(RESL_OFF, b[7:0] ^ 8'h40);
    rd(STS_OFF, 8'h04);
    $display("abort done");
    repeat (3) @(posedge sys_clk);
    report_and_stop();
  end
endmodule : testbench
